// ===== cbx_pkg.sv
// constants, types and offset arithmetic for the compact branch and trap executor
package cbx_pkg;

    // trap entry
    localparam logic [31:0] TRAP_VECTOR   = 32'h0000_0008;
    localparam logic [4:0]  MODE_SVC      = 5'h13;
    localparam int          MODE_MSB      = 4;
    localparam int          STATE_BIT     = 5;
    localparam int          TRAP_CYCLES   = 3;

    // program counter arithmetic
    localparam logic [31:0] PREFETCH_AHEAD = 32'h0000_0004;
    localparam logic [31:0] NEXT_HALF      = 32'h0000_0002;
    localparam logic [31:0] LINK_MARK      = 32'h0000_0001;

    // opcode fields
    localparam logic [7:0]  OP_TRAP    = 8'hDF;
    localparam logic [4:0]  OP_BRANCH  = 5'h1C;
    localparam logic [4:0]  OP_LONG_HI = 5'h1E;
    localparam logic [4:0]  OP_LONG_LO = 5'h1F;

    typedef enum logic [0:0]
    {
        ST_IDLE = 1'h0,
        ST_TRAP = 1'h1
    } cbx_state_t;

    // one register write toward the core
    typedef struct packed
    {
        logic        we;
        logic [31:0] data;
    } cbx_wr_t;

    typedef struct packed
    {
        cbx_state_t  st;
        logic [3:0]  cnt;
        logic [31:0] addr;
        logic [31:0] status;
        cbx_wr_t     pc_wr;
        cbx_wr_t     lr_wr;
        cbx_wr_t     saved_status_word_wr;
        cbx_wr_t     current_status_word_wr;
    } cbx_regs_t;

    // sign-extended displacement; upper half lands at bit 12, others at bit 1
    function automatic logic [31:0] disp_ext(input logic [10:0] field, input logic upper);
        logic [31:0] r;
        if (upper)
        begin
            r = {{9{field[10]}}, field, 12'h000};
        end
        else
        begin
            r = {{20{field[10]}}, field, 1'h0};
        end
        return r;
    endfunction

endpackage

// ===== cbx_disp_adder.sv
// adds a decoded branch displacement to a base address
`timescale 1ns/1ps
module cbx_disp_adder
(
    // operands
    input  wire logic [31:0] base_i,
    input  wire logic [10:0] field_i,
    input  wire logic        upper_i,
    // result
    output logic      [31:0] sum_o
);

    // wraps modulo 2^32 by width
    assign sum_o = base_i + cbx_pkg::disp_ext(field_i, upper_i);

endmodule

// ===== cbx_exec.sv
// executes the 16-bit trap, short branch and two-part long call instructions
`timescale 1ns/1ps
module cbx_exec
#(
    parameter int TRAP_CYCLES = cbx_pkg::TRAP_CYCLES
)
(
    // clock and reset
    input  wire logic            CLOCK_I,
    input  wire logic            RESETN_I,
    // instruction in, ready out
    input  wire logic            INSTR_VALID_I,
    input  wire logic [15:0]     INSTR_I,
    input  wire logic [31:0]     INSTR_ADDR_I,
    output logic                 READY_O,
    // core state in
    input  wire logic [31:0]     LR_I,
    input  wire logic [31:0]     CURRENT_STATUS_WORD_I,
    // register writes out
    output cbx_pkg::cbx_wr_t     PC_WR_O,
    output cbx_pkg::cbx_wr_t     LR_WR_O,
    output cbx_pkg::cbx_wr_t     SAVED_STATUS_WORD_WR_O,
    output cbx_pkg::cbx_wr_t     CURRENT_STATUS_WORD_WR_O
);

    localparam int          TRAP_DLY = TRAP_CYCLES;
    localparam logic [3:0]  TRAP_CNT = 4'(TRAP_CYCLES);

    cbx_pkg::cbx_regs_t q;
    cbx_pkg::cbx_regs_t d;

    logic        is_trap;
    logic        is_branch;
    logic        is_long_hi;
    logic        is_long_lo;
    logic        take;
    logic [31:0] pc_ahead;
    logic [31:0] base;
    logic [31:0] target;

    // only the top byte is decoded, the comment byte never steers anything
    assign is_trap    = INSTR_I[15:8] == cbx_pkg::OP_TRAP;
    assign is_branch  = INSTR_I[15:11] == cbx_pkg::OP_BRANCH;
    assign is_long_hi = INSTR_I[15:11] == cbx_pkg::OP_LONG_HI;
    assign is_long_lo = INSTR_I[15:11] == cbx_pkg::OP_LONG_LO;

    assign READY_O = q.st == cbx_pkg::ST_IDLE;
    assign take    = INSTR_VALID_I && READY_O;

    // prefetch puts the visible pc one word ahead
    assign pc_ahead = INSTR_ADDR_I + cbx_pkg::PREFETCH_AHEAD;
    // second long half builds on the partial sum left in the link register
    assign base     = is_long_lo ? LR_I : pc_ahead;

    cbx_disp_adder u_adder
    (
        .base_i  (base),
        .field_i (INSTR_I[10:0]),
        .upper_i (is_long_hi),
        .sum_o   (target)
    );

    always_comb
    begin
        d = q;
        d.pc_wr.we   = 1'h0;
        d.lr_wr.we   = 1'h0;
        d.saved_status_word_wr.we = 1'h0;
        d.current_status_word_wr.we = 1'h0;
        case (q.st)
            cbx_pkg::ST_IDLE:
            begin
                if (take && is_trap)
                begin
                    // hold the result back to match the 32-bit trap timing
                    d.st     = cbx_pkg::ST_TRAP;
                    d.cnt    = TRAP_CNT;
                    d.addr   = INSTR_ADDR_I;
                    d.status = CURRENT_STATUS_WORD_I;
                end
                else if (take && is_branch)
                begin
                    d.pc_wr.we   = 1'h1;
                    d.pc_wr.data = target;
                end
                else if (take && is_long_hi)
                begin
                    d.lr_wr.we   = 1'h1;
                    d.lr_wr.data = target;
                end
                else if (take && is_long_lo)
                begin
                    d.pc_wr.we   = 1'h1;
                    d.pc_wr.data = target;
                    d.lr_wr.we   = 1'h1;
                    d.lr_wr.data = (INSTR_ADDR_I + cbx_pkg::NEXT_HALF) | cbx_pkg::LINK_MARK;
                end
            end
            cbx_pkg::ST_TRAP:
            begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h2)
                begin
                    d.st         = cbx_pkg::ST_IDLE;
                    d.lr_wr.we   = 1'h1;
                    d.lr_wr.data = q.addr + cbx_pkg::NEXT_HALF;
                    d.pc_wr.we   = 1'h1;
                    d.pc_wr.data = cbx_pkg::TRAP_VECTOR;
                    d.saved_status_word_wr.we   = 1'h1;
                    d.saved_status_word_wr.data = q.status;
                    d.current_status_word_wr.we   = 1'h1;
                    d.current_status_word_wr.data = q.status;
                    d.current_status_word_wr.data[cbx_pkg::MODE_MSB:0] = cbx_pkg::MODE_SVC;
                    d.current_status_word_wr.data[cbx_pkg::STATE_BIT]  = 1'h0;
                end
            end
            default:
            begin
                d.st = cbx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign PC_WR_O   = q.pc_wr;
    assign LR_WR_O   = q.lr_wr;
    assign SAVED_STATUS_WORD_WR_O = q.saved_status_word_wr;
    assign CURRENT_STATUS_WORD_WR_O = q.current_status_word_wr;

    // checks
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESETN_I);

    sequence s_trap_taken;
        take && is_trap;
    endsequence

    sequence s_trap_quiet;
        !PC_WR_O.we && !READY_O;
    endsequence

    a_trap_vector_load: assert property (s_trap_taken |-> ##TRAP_DLY (PC_WR_O.we && PC_WR_O.data == 32'h0000_0008))
        else $error("trap did not load the vector");

    a_trap_link_addr: assert property (s_trap_taken |-> ##TRAP_DLY (LR_WR_O.we
        && LR_WR_O.data == $past(INSTR_ADDR_I, TRAP_DLY) + 32'h0000_0002))
        else $error("trap link address wrong");

    a_trap_status_save: assert property (s_trap_taken |-> ##TRAP_DLY (SAVED_STATUS_WORD_WR_O.we
        && SAVED_STATUS_WORD_WR_O.data == $past(CURRENT_STATUS_WORD_I, TRAP_DLY)))
        else $error("trap did not save status word");

    a_trap_mode_state: assert property (CURRENT_STATUS_WORD_WR_O.we |-> (CURRENT_STATUS_WORD_WR_O.data[4:0] == 5'h13
        && !CURRENT_STATUS_WORD_WR_O.data[5] && SAVED_STATUS_WORD_WR_O.we))
        else $error("trap mode or state wrong");

    a_trap_cycle_count: assert property (s_trap_taken |=> s_trap_quiet [*2] ##1 READY_O)
        else $error("trap cycle count wrong");

    a_branch_target: assert property (take && is_branch |=> (PC_WR_O.we && !LR_WR_O.we
        && PC_WR_O.data == $past(INSTR_ADDR_I) + 32'h0000_0004
        + {{20{$past(INSTR_I[10])}}, $past(INSTR_I[10:0]), 1'h0}))
        else $error("short branch target wrong");

    a_long_upper_half: assert property (take && is_long_hi |=> (LR_WR_O.we && !PC_WR_O.we
        && LR_WR_O.data == $past(INSTR_ADDR_I) + 32'h0000_0004
        + {{9{$past(INSTR_I[10])}}, $past(INSTR_I[10:0]), 12'h000}))
        else $error("long call upper half wrong");

    a_long_lower_half: assert property (take && is_long_lo |=> (PC_WR_O.we
        && PC_WR_O.data == $past(LR_I) + {{20{$past(INSTR_I[10])}}, $past(INSTR_I[10:0]), 1'h0}))
        else $error("long call target wrong");

    // the or must bind inside the compare, otherwise the check is always true
    a_long_link_mark: assert property (take && is_long_lo |=> (LR_WR_O.we
        && LR_WR_O.data == (($past(INSTR_ADDR_I) + 32'h0000_0002) | 32'h0000_0001)))
        else $error("long call return address wrong");

    // the core must see nothing until the trap delay has run out
    a_trap_no_early: assert property (!READY_O |-> !(PC_WR_O.we || LR_WR_O.we || SAVED_STATUS_WORD_WR_O.we || CURRENT_STATUS_WORD_WR_O.we))
        else $error("register write while trap in flight");

    a_trap_writes_pair: assert property (SAVED_STATUS_WORD_WR_O.we |-> (CURRENT_STATUS_WORD_WR_O.we && LR_WR_O.we && PC_WR_O.we))
        else $error("trap writes not issued together");

    a_other_quiet: assert property (take && !is_trap && !is_branch && !is_long_hi && !is_long_lo
        |=> !(PC_WR_O.we || LR_WR_O.we || SAVED_STATUS_WORD_WR_O.we || CURRENT_STATUS_WORD_WR_O.we))
        else $error("unknown opcode wrote a register");

endmodule

// ===== cbx_testbench.sv
// self-checking bench for the compact branch and trap executor
`timescale 1ns/1ps
module testbench;
    logic             clock_i;
    logic             resetn_i;
    logic             instr_valid_i;
    logic [15:0]      instr_i;
    logic [31:0]      instr_addr_i;
    logic [31:0]      lr_i;
    logic [31:0]      current_status_word_i;
    logic             ready_o;
    cbx_pkg::cbx_wr_t pc_wr_o;
    cbx_pkg::cbx_wr_t lr_wr_o;
    cbx_pkg::cbx_wr_t saved_status_word_wr_o;
    cbx_pkg::cbx_wr_t current_status_word_wr_o;
    int               err_count;
    int               checks;

    cbx_exec DUT
    (
        .CLOCK_I       (clock_i),
        .RESETN_I      (resetn_i),
        .INSTR_VALID_I (instr_valid_i),
        .INSTR_I       (instr_i),
        .INSTR_ADDR_I  (instr_addr_i),
        .READY_O       (ready_o),
        .LR_I          (lr_i),
        .CURRENT_STATUS_WORD_I        (current_status_word_i),
        .PC_WR_O       (pc_wr_o),
        .LR_WR_O       (lr_wr_o),
        .SAVED_STATUS_WORD_WR_O     (saved_status_word_wr_o),
        .CURRENT_STATUS_WORD_WR_O     (current_status_word_wr_o)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // sign extension first, so negative offsets wrap correctly in 32 bits
    function automatic logic [31:0] disp(input logic [10:0] f, input logic up);
        return up ? {{21{f[10]}}, f} << 12 : {{21{f[10]}}, f} << 1;
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // returns 1 ns after the edge that takes the instruction
    task automatic issue(input logic [15:0] ins, input logic [31:0] a, input logic [31:0] l, input logic [31:0] c);
        @(posedge clock_i);
        instr_valid_i <= 1'h1;
        instr_i       <= ins;
        instr_addr_i  <= a;
        lr_i          <= l;
        current_status_word_i        <= c;
        @(posedge clock_i);
        instr_valid_i <= 1'h0;
        #1;
    endtask

    task automatic branch(input logic [10:0] f, input logic [31:0] a);
        issue({cbx_pkg::OP_BRANCH, f}, a, 32'($urandom), 32'($urandom));
        chk("branch pc", pc_wr_o, {1'b1, a + 32'h4 + disp(f, 1'b0)});
        @(posedge clock_i);
        #1;
        chk("branch pulse", 33'(pc_wr_o.we), 33'h0);
    endtask

    task automatic long_call(input logic [10:0] hi, input logic [10:0] lo, input logic [31:0] a);
        logic [31:0] lr;
        lr = a + 32'h4 + disp(hi, 1'b1);
        issue({cbx_pkg::OP_LONG_HI, hi}, a, 32'($urandom), 32'($urandom));
        chk("upper lr", lr_wr_o, {1'h1, lr});
        // the core hands the partial sum back on the link register input
        issue({cbx_pkg::OP_LONG_LO, lo}, a + 32'h2, lr, 32'($urandom));
        chk("lower pc", pc_wr_o, {1'b1, lr + disp(lo, 1'b0)});
        chk("lower lr", lr_wr_o, {1'b1, (a + 32'h4) | 32'h1});
    endtask

    task automatic trap(input logic [7:0] cm, input logic [31:0] a, input logic [31:0] cp);
        int n;
        issue({cbx_pkg::OP_TRAP, cm}, a, 32'($urandom), cp);
        chk("trap busy", 33'(ready_o), 33'h0);
        n = 1;
        while (pc_wr_o.we !== 1'b1 && n < 8)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk("trap cycles", 33'(n), 33'(cbx_pkg::TRAP_CYCLES));
        if (n >= 8)
            print_verdict();
        chk("trap pc", pc_wr_o, {1'b1, 32'h8});
        chk("trap lr", lr_wr_o, {1'b1, a + 32'h2});
        chk("trap saved_status_word", saved_status_word_wr_o, {1'b1, cp});
        chk("trap current_status_word", current_status_word_wr_o, {1'b1, cp[31:6], 1'b0, cbx_pkg::MODE_SVC});
        chk("trap ready", 33'(ready_o), 33'h1);
    endtask

    initial
    begin
        resetn_i      = 1'b0;
        instr_valid_i = 1'b0;
        instr_i       = 16'h0000;
        instr_addr_i  = 32'h0000_0000;
        lr_i          = 32'h0000_0000;
        current_status_word_i        = 32'h0000_0030;
        err_count     = 0;
        checks        = 0;
        void'($urandom(32'h25A0));
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1;
        chk("reset pc", pc_wr_o, 33'h0);
        chk("reset ready", 33'(ready_o), 33'h1);
        $display("test reset done");
        branch(11'h3FF, 32'h0000_1000);
        branch(11'h400, 32'h0000_1000);
        branch(11'h7FF, 32'hFFFF_FFFC);
        repeat (20) branch(11'($urandom), {31'($urandom), 1'h0});
        $display("test short branch done");
        long_call(11'h400, 11'h7FF, 32'h0000_0000);
        long_call(11'h3FF, 11'h3FF, 32'hFFFF_F000);
        repeat (20) long_call(11'($urandom), 11'($urandom), {31'($urandom), 1'h0});
        $display("test long call done");
        trap(8'h00, 32'h0000_0100, 32'h0000_0030);
        trap(8'hFF, 32'h0000_0100, 32'hF000_003F);
        repeat (10) trap(8'($urandom), {31'($urandom), 1'h0}, $urandom);
        $display("test trap done");
        issue(16'h0000, 32'h0000_0200, 32'($urandom), 32'($urandom));
        chk("other op", 33'({pc_wr_o.we, lr_wr_o.we, saved_status_word_wr_o.we, current_status_word_wr_o.we}), 33'h0);
        $display("test other opcode done");
        print_verdict();
    end
endmodule
